// File: inc/cxs_pkg.sv
// shared constants for the rotate-to-exclusive-or execution slice
package cxs_pkg;
  // opcodes, fixed forms
  localparam logic [7:0] OP_ROT_RIGHT_CY = 8'h13;
  localparam logic [7:0] OP_SET_CARRY = 8'hd3;
  localparam logic [7:0] OP_SET_BIT = 8'hd2;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_SWAP = 8'hc4;
  localparam logic [7:0] OP_EXOR_DIR_ACC = 8'h62;
  localparam logic [7:0] OP_EXOR_DIR_IMM = 8'h63;
  // opcode families in the high nibble, digit exchange in the high seven bits
  localparam logic [3:0] HI_SUB_BORROW = 4'h9;
  localparam logic [3:0] HI_EXOR = 4'h6;
  localparam logic [3:0] HI_EXCHANGE = 4'hc;
  localparam logic [6:0] HI_DIGIT_XCHG = 7'h6b; // 0xd6/0xd7 without bit 0
  // low-bits source forms
  localparam logic [2:0] LO_IMM = 3'h4;
  localparam logic [2:0] LO_DIR = 3'h5;
  localparam logic [1:0] LO_IND = 2'h3;
  // write-back target kinds
  localparam logic [1:0] WR_REG = 2'h0;
  localparam logic [1:0] WR_DIR = 2'h1;
  localparam logic [1:0] WR_IND = 2'h2;
  // reset values and fixed steps
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] PC_STEP_JUMP = 16'h0002;
  // machine cycles, one core clock each
  localparam int LONG_OP_CYCLES = 2;
endpackage : cxs_pkg

// File: sim/cxs_exec_bench.sv
// self-checking bench for the rotate-to-exclusive-or execution slice
`timescale 1ns/100ps
module cxs_exec_bench;
  import cxs_pkg::*;
  logic core_clk_i, rst_i, instr_valid_i, dir_is_port_i;
  logic [7:0] opcode_i, byte2_i, byte3_i, opnd_data_i, port_latch_i;
  logic ready_o, done_o, illegal_o, cy_o, ac_o, ov_o, wr_en_o, bit_wr_o;
  logic [7:0] acc_o, wr_addr_o, wr_data_o, bit_addr_o;
  logic [15:0] pc_o;
  logic [1:0] wr_kind_o;
  logic [7:0] m_acc;
  logic m_cy, m_ac, m_ov;
  logic [15:0] m_pc;
  logic [55:0] exp_q[$];
  logic [55:0] e;
  integer seed, n_mismatch, n_compared;

  cxs_exec uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .instr_valid_i(instr_valid_i), .opcode_i(opcode_i), .byte2_i(byte2_i),
    .byte3_i(byte3_i), .opnd_data_i(opnd_data_i),
    .dir_is_port_i(dir_is_port_i), .port_latch_i(port_latch_i),
    .ready_o(ready_o), .done_o(done_o), .illegal_o(illegal_o),
    .acc_o(acc_o), .cy_o(cy_o), .ac_o(ac_o), .ov_o(ov_o), .pc_o(pc_o),
    .wr_en_o(wr_en_o), .wr_kind_o(wr_kind_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .bit_wr_o(bit_wr_o), .bit_addr_o(bit_addr_o));

  task chk(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // model one instruction, note the result, then present it
  task run_op(input logic [7:0] op);
    logic [7:0] b2, b3, dat, lat, src, base, wa, wd, d6;
    logic [8:0] d;
    logic [4:0] dl;
    logic [1:0] k;
    logic port, ill, cw, cb, lng;
    b2 = 8'($random(seed));
    b3 = 8'($random(seed));
    dat = 8'($random(seed));
    lat = 8'($random(seed));
    port = 1'($random(seed));
    ill = !(op == OP_ROT_RIGHT_CY || op == OP_SET_CARRY ||
      op == OP_SET_BIT || op == OP_SHORT_JUMP || op == OP_SWAP ||
      (op >= 8'h94 && op <= 8'h9f) ||
      (op >= 8'hc5 && op <= 8'hcf) || op[7:1] == HI_DIGIT_XCHG ||
      (op >= 8'h62 && op <= 8'h6f));
    lng = (op == OP_SHORT_JUMP || op == OP_EXOR_DIR_IMM);
    src = (op[3:0] == 4'h4) ? b2 : dat; // immediate forms take byte two
    base = port ? lat : dat;
    cw = 1'b0;
    cb = 1'b0;
    k = WR_REG;
    wa = 8'h00;
    wd = 8'h00;
    if (ill) begin
    end else if (op == OP_ROT_RIGHT_CY) begin
      {m_acc, m_cy} = {m_cy, m_acc};
      m_pc += 16'h1;
    end else if (op == OP_SET_CARRY) begin
      m_cy = 1'b1;
      m_pc += 16'h1;
    end else if (op == OP_SET_BIT) begin
      cb = 1'b1;
      m_pc += 16'h2;
    end else if (op == OP_SHORT_JUMP) begin
      m_pc = m_pc + PC_STEP_JUMP + {{8{b2[7]}}, b2};
    end else if (op == OP_SWAP) begin
      m_acc = {m_acc[3:0], m_acc[7:4]};
      m_pc += 16'h1;
    end else if (op[7:4] == HI_SUB_BORROW) begin
      d = {1'b0, m_acc} - {1'b0, src} - {8'h00, m_cy};
      dl = {1'b0, m_acc[3:0]} - {1'b0, src[3:0]} - {4'h0, m_cy};
      d6 = {1'b0, m_acc[6:0]} - {1'b0, src[6:0]} - {7'h00, m_cy};
      m_ac = dl[4];
      m_ov = d[8] ^ d6[7];
      m_cy = d[8];
      m_acc = d[7:0];
      m_pc += (op[3:1] == 3'h2) ? 16'h2 : 16'h1;
    end else if (op[7:4] == HI_EXOR && op[3:2] != 2'h0) begin
      m_acc ^= src;
      m_pc += (op[3:1] == 3'h2) ? 16'h2 : 16'h1;
    end else if (op[7:4] == HI_EXOR) begin
      cw = 1'b1;
      k = WR_DIR;
      wa = b2;
      wd = base ^ (op[0] ? b3 : m_acc);
      m_pc += op[0] ? 16'h3 : 16'h2;
    end else if (op[7:4] == HI_EXCHANGE) begin
      cw = 1'b1;
      wd = m_acc;
      m_acc = dat;
      k = op[3] ? WR_REG : (op[1] ? WR_IND : WR_DIR);
      wa = op[3] ? {5'h00, op[2:0]} : (op[1] ? {7'h00, op[0]} : b2);
      m_pc += (op == 8'hc5) ? 16'h2 : 16'h1;
    end else begin
      cw = 1'b1;
      k = WR_IND;
      wa = {7'h00, op[0]};
      wd = {dat[7:4], m_acc[3:0]};
      m_acc = {m_acc[7:4], dat[3:0]};
      m_pc += 16'h1;
    end
    exp_q.push_back({ill, cw, cb, m_acc, m_cy, m_ac, m_ov, m_pc, k, wa, wd,
      b2});
    instr_valid_i = 1'b1;
    opcode_i = op;
    byte2_i = b2;
    byte3_i = b3;
    opnd_data_i = dat;
    port_latch_i = lat;
    dir_is_port_i = port;
    @(negedge core_clk_i);
    // write strobes pulse only in the cycle after the accepting edge
    chk({14'h0, wr_en_o, bit_wr_o}, {14'h0, cw, cb});
    // a long op refuses the request offered in its gap cycle
    if (lng && !ill) begin
      chk({15'h0, ready_o}, 16'h0);
      opcode_i = 8'($random(seed));
      @(negedge core_clk_i);
    end
  endtask : run_op

  // result watcher: each done or illegal pulse retires the oldest note
  always @(negedge core_clk_i) begin
    if (!rst_i && (done_o === 1'b1 || illegal_o === 1'b1)) begin
      if (exp_q.size() == 0) begin
        chk(16'h1, 16'h0);
      end else begin
        e = exp_q.pop_front();
        chk({14'h0, illegal_o, done_o}, {14'h0, e[55], !e[55]});
        chk({5'h0, acc_o, cy_o, ac_o, ov_o}, {5'h0, e[52:42]});
        chk(pc_o, e[41:26]);
        if (e[54])
          chk({6'h0, wr_kind_o, wr_data_o},
            {6'h0, e[25:24], e[15:8]});
        if (e[54]) chk({8'h0, wr_addr_o}, {8'h0, e[23:16]});
        if (e[53]) chk({7'h0, bit_wr_o, bit_addr_o}, {8'h1, e[7:0]});
      end
    end
  end

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // watchdog: whole run needs about 530 cycles
  initial begin
    #(5000 * 50);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    seed = 32'hfbc1;
    n_mismatch = 0;
    n_compared = 0;
    {instr_valid_i, dir_is_port_i, opcode_i, byte2_i} = 18'h0;
    {byte3_i, opnd_data_i, port_latch_i} = 24'h0;
    {m_acc, m_cy, m_ac, m_ov, m_pc} = {ACC_RST, 3'h0, PC_RST};
    rst_i = 1'b1;
    repeat (10) @(negedge core_clk_i);
    rst_i = 1'b0;
    // every opcode twice, back to back, legal and illegal alike
    repeat (2) for (int i = 0; i < 256; i++) run_op(i[7:0]);
    instr_valid_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    chk(16'(exp_q.size()), 16'h0);
    give_verdict;
  end
endmodule : cxs_exec_bench

// File: src/cxs_exec.sv
// execution slice: rotate, bit set, short jump, subtract, swaps, xor
// Notes on behaviour
// RULE1: 0x13 rotates accumulator right via carry; bit0 to carry, carry to bit7
// RULE2: 0xd3 sets carry; 0xd2 plus bit address sets that bit; one cycle
// RULE3: 0x80 adds two to pc, then the sign-extended displacement byte
// RULE4: subtract source and carry from accumulator, result to accumulator
// RULE5: carry is borrow out of bit 7; auxiliary carry is borrow of bit 3
// RULE6: overflow is borrow into bit 7 exclusive-or borrow out of bit 7
// RULE7: subtract forms: 0x98+n register, 0x95 direct, 0x96+i indirect, 0x94
// RULE8: 0xc4 swaps accumulator nibbles, flags untouched
// RULE9: exchange accumulator with register, direct or indirect byte, no flags
// RULE10: 0xd6+i swaps low nibbles of accumulator and indirect byte
// RULE11: exclusive-or stores result in destination, flags untouched
// RULE12: xor into accumulator: 0x68+n, 0x65, 0x66+i, 0x64, one cycle each
// RULE13: xor into direct: 0x62 from accumulator, 0x63 immediate in two cycles
// RULE14: xor on an output port reads the output latch, not the pins
`timescale 1ns/100ps
module cxs_exec
  import cxs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] byte2_i,
  input wire logic [7:0] byte3_i,
  input wire logic [7:0] opnd_data_i,
  input wire logic dir_is_port_i,
  input wire logic [7:0] port_latch_i,
  output logic ready_o,
  output logic done_o,
  output logic illegal_o,
  output logic [7:0] acc_o,
  output logic cy_o,
  output logic ac_o,
  output logic ov_o,
  output logic [15:0] pc_o,
  output logic wr_en_o,
  output logic [1:0] wr_kind_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic bit_wr_o,
  output logic [7:0] bit_addr_o
);

  typedef enum logic [1:0] {
    CXS_IDLE = 2'b01,
    CXS_WAIT = 2'b10
  } cxs_state_t;

  cxs_state_t state_q, state_d;
  logic accept;

  // instruction family decode
  logic is_rrc, is_setc, is_setbit, is_short_relative_jump, is_swap;
  logic is_subtract_with_borrow, is_xrl_a, is_xrl_da, is_xrl_di, is_xch, is_digit_exchange_op;
  logic is_legal, is_long;
  assign is_rrc = opcode_i == OP_ROT_RIGHT_CY; // RULE1
  assign is_setc = opcode_i == OP_SET_CARRY; // RULE2
  assign is_setbit = opcode_i == OP_SET_BIT; // RULE2
  assign is_short_relative_jump = opcode_i == OP_SHORT_JUMP; // RULE3
  assign is_swap = opcode_i == OP_SWAP; // RULE8
  assign is_subtract_with_borrow = opcode_i[7:4] == HI_SUB_BORROW
                   && (opcode_i[3] || opcode_i[2]); // RULE7
  assign is_xrl_a = opcode_i[7:4] == HI_EXOR
                    && (opcode_i[3] || opcode_i[2]); // RULE12
  assign is_xrl_da = opcode_i == OP_EXOR_DIR_ACC; // RULE13
  assign is_xrl_di = opcode_i == OP_EXOR_DIR_IMM; // RULE13
  assign is_xch = opcode_i[7:4] == HI_EXCHANGE
                  && (opcode_i[3] || opcode_i[2:0] == LO_DIR
                      || opcode_i[2:1] == LO_IND); // RULE9
  assign is_digit_exchange_op = opcode_i[7:1] == HI_DIGIT_XCHG; // RULE10
  assign is_legal = is_rrc | is_setc | is_setbit | is_short_relative_jump | is_swap
                    | is_subtract_with_borrow | is_xrl_a | is_xrl_da | is_xrl_di
                    | is_xch | is_digit_exchange_op;
  assign is_long = is_short_relative_jump | is_xrl_di; // two machine cycles
  assign accept = instr_valid_i && state_q == CXS_IDLE;

  // source addressing mode from the low opcode bits
  logic src_reg, src_dir, src_ind, src_imm;
  assign src_reg = opcode_i[3];
  assign src_dir = !opcode_i[3] && opcode_i[2:0] == LO_DIR;
  assign src_ind = !opcode_i[3] && opcode_i[2:1] == LO_IND;
  assign src_imm = !opcode_i[3] && opcode_i[2:0] == LO_IMM;

  // read-modify-write of a port must see the latch, pins may be loaded
  logic [7:0] dst_val, src_val;
  assign dst_val = (is_xrl_da || is_xrl_di) && dir_is_port_i
                   ? port_latch_i : opnd_data_i; // RULE14
  assign src_val = src_imm ? byte2_i : opnd_data_i;

  // subtract with borrow, three borrow taps from nested narrow subtracts
  logic [8:0] sub_full;
  logic [7:0] sub_low7;
  logic [4:0] sub_low4;
  logic bor7, bor6, bor3;
  assign sub_full = {1'b0, acc_o} - {1'b0, src_val}
                    - {8'h00, cy_o}; // RULE4
  assign sub_low7 = {1'b0, acc_o[6:0]} - {1'b0, src_val[6:0]}
                    - {7'h00, cy_o};
  assign sub_low4 = {1'b0, acc_o[3:0]} - {1'b0, src_val[3:0]}
                    - {4'h0, cy_o};
  assign bor7 = sub_full[8]; // RULE5
  assign bor6 = sub_low7[7]; // RULE6
  assign bor3 = sub_low4[4]; // RULE5

  // program counter: short jump adds two, then the signed offset
  logic [15:0] pc_rel, pc_len, pc_next;
  assign pc_rel = pc_o + PC_STEP_JUMP
                  + {{8{byte2_i[7]}}, byte2_i}; // RULE3
  assign pc_len = pc_o + (is_xrl_di ? 16'h0003
                  : (is_setbit || is_xrl_da || src_dir || src_imm)
                    && !is_swap && !is_rrc && !is_setc && !is_digit_exchange_op
                    && !(is_xch && !src_dir) ? 16'h0002 : 16'h0001);
  assign pc_next = is_short_relative_jump ? pc_rel : pc_len;

  // accumulator and flag next values
  logic [7:0] acc_next;
  logic cy_next, ac_next, ov_next;
  assign acc_next = is_rrc ? {cy_o, acc_o[7:1]} // RULE1
                  : is_subtract_with_borrow ? sub_full[7:0] // RULE4
                  : is_swap ? {acc_o[3:0], acc_o[7:4]} // RULE8
                  : is_xch ? opnd_data_i // RULE9
                  : is_digit_exchange_op ? {acc_o[7:4], opnd_data_i[3:0]} // RULE10
                  : is_xrl_a ? acc_o ^ src_val // RULE11
                  : acc_o;
  assign cy_next = is_rrc ? acc_o[0] // RULE1
                 : is_setc ? 1'b1 // RULE2
                 : is_subtract_with_borrow ? bor7 // RULE5
                 : cy_o;
  assign ac_next = is_subtract_with_borrow ? bor3 : ac_o; // RULE5
  assign ov_next = is_subtract_with_borrow ? bor6 ^ bor7 : ov_o; // RULE6

  // byte write-back for exchanges and xor into a direct byte
  logic wr_next;
  logic [1:0] kind_next;
  logic [7:0] addr_next, data_next;
  assign wr_next = is_xch | is_digit_exchange_op | is_xrl_da | is_xrl_di;
  assign kind_next = (is_xrl_da || is_xrl_di || src_dir) ? WR_DIR
                   : (src_reg && is_xch) ? WR_REG : WR_IND;
  assign addr_next = kind_next == WR_DIR ? byte2_i
                   : kind_next == WR_REG ? {5'h00, opcode_i[2:0]}
                   : {7'h00, opcode_i[0]};
  assign data_next = is_xch ? acc_o // RULE9
                   : is_digit_exchange_op ? {opnd_data_i[7:4], acc_o[3:0]} // RULE10
                   : is_xrl_da ? dst_val ^ acc_o // RULE13
                   : dst_val ^ byte3_i; // RULE13

  // sequencer: long ops hold off the next request for one more cycle
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CXS_IDLE: begin
        if (accept && is_legal && is_long) begin
          state_d = CXS_WAIT; // RULE3 RULE13
        end
      end
      CXS_WAIT: begin
        state_d = CXS_IDLE;
      end
      default: begin
        state_d = CXS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= CXS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // handshake outputs; done marks the final machine cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b1;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      ready_o <= state_d == CXS_IDLE;
      // an illegal opcode pulses illegal_o only, never done_o
      done_o <= (accept && is_legal && !is_long) || state_q == CXS_WAIT;
      illegal_o <= accept && !is_legal;
    end
  end

  // architectural state commits on the accepting edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      acc_o <= ACC_RST;
      cy_o <= 1'b0;
      ac_o <= 1'b0;
      ov_o <= 1'b0;
      pc_o <= PC_RST;
    end else if (accept && is_legal) begin
      acc_o <= acc_next;
      cy_o <= cy_next;
      ac_o <= ac_next;
      ov_o <= ov_next;
      pc_o <= pc_next;
    end
  end

  // write strobes last one cycle; data stands until the next write
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_en_o <= 1'b0;
      wr_kind_o <= WR_REG;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
      bit_wr_o <= 1'b0;
      bit_addr_o <= 8'h00;
    end else begin
      wr_en_o <= accept && wr_next;
      bit_wr_o <= accept && is_setbit; // RULE2
      if (accept && wr_next) begin
        wr_kind_o <= kind_next;
        wr_addr_o <= addr_next;
        wr_data_o <= data_next;
      end
      if (accept && is_setbit) begin
        bit_addr_o <= byte2_i;
      end
    end
  end

  // checks, sampled one edge after the accepting edge
  default clocking cxs_cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  rrc_rotate_a: assert property (accept && is_rrc |=> // RULE1
    acc_o == {$past(cy_o), $past(acc_o[7:1])} && cy_o == $past(acc_o[0])
    && ac_o == $past(ac_o) && ov_o == $past(ov_o))
    else $error("rotate through carry wrong");
  bit_set_op_target_a: assert property (accept && (is_setc || is_setbit) |=> // RULE2
    (cy_o || bit_wr_o) && done_o && acc_o == $past(acc_o))
    else $error("bit set wrong");
  short_relative_jump_target_a: assert property (accept && is_short_relative_jump |=> // RULE3
    pc_o == $past(pc_o) + 16'h0002 + {{8{$past(byte2_i[7])}},
    $past(byte2_i)} && !done_o ##1 done_o)
    else $error("short jump target or timing wrong");
  subtract_with_borrow_result_a: assert property (accept && is_subtract_with_borrow |=> // RULE4
    acc_o == $past(acc_o) - $past(src_val) - {7'h00, $past(cy_o)})
    else $error("subtract result wrong");
  subtract_with_borrow_borrow_a: assert property (accept && is_subtract_with_borrow |=> // RULE5
    cy_o == ({1'b0, $past(acc_o)} < {1'b0, $past(src_val)}
    + {8'h00, $past(cy_o)}) && ac_o == ({1'b0, $past(acc_o[3:0])}
    < {1'b0, $past(src_val[3:0])} + {4'h0, $past(cy_o)}))
    else $error("subtract borrow flags wrong");
  subtract_with_borrow_overflow_a: assert property (accept && is_subtract_with_borrow |=> // RULE6
    ov_o == (($past(acc_o[7]) != $past(src_val[7]))
    && (acc_o[7] != $past(acc_o[7]))))
    else $error("subtract overflow wrong");
  swap_nibble_a: assert property (accept && is_swap |=> // RULE8
    acc_o == {$past(acc_o[3:0]), $past(acc_o[7:4])} && cy_o == $past(cy_o))
    else $error("nibble swap wrong");
  xch_both_a: assert property (accept && is_xch |=> // RULE9
    wr_en_o && wr_data_o == $past(acc_o) && acc_o == $past(opnd_data_i)
    && cy_o == $past(cy_o))
    else $error("exchange wrong");
  digit_exchange_op_digit_a: assert property (accept && is_digit_exchange_op |=> // RULE10
    wr_data_o == {$past(opnd_data_i[7:4]), $past(acc_o[3:0])}
    && acc_o == {$past(acc_o[7:4]), $past(opnd_data_i[3:0])})
    else $error("digit exchange wrong");
  xrl_acc_a: assert property (accept && is_xrl_a |=> // RULE12
    acc_o == ($past(acc_o) ^ $past(src_val)) && ov_o == $past(ov_o) && done_o)
    else $error("xor into accumulator wrong");
  xrl_port_a: assert property (accept && is_xrl_di && dir_is_port_i |=> // RULE14
    wr_data_o == ($past(port_latch_i) ^ $past(byte3_i)) && !done_o ##1 done_o)
    else $error("xor on port not from latch");

  // refusals, lengths and untouched flags
  bad_opcode_a: assert property (accept && !is_legal |=> // RULE7
    illegal_o && !done_o && !wr_en_o && acc_o == $past(acc_o)
    && pc_o == $past(pc_o))
    else $error("illegal opcode changed state");
  dir_from_acc_a: assert property (accept && is_xrl_da |=> // RULE13
    wr_en_o && wr_data_o == ($past(dst_val) ^ $past(acc_o))
    && acc_o == $past(acc_o) && done_o)
    else $error("xor into direct byte wrong");
  sub_length_a: assert property (accept && is_subtract_with_borrow |=> // RULE7
    pc_o == $past(pc_o) + (($past(src_dir) || $past(src_imm))
    ? 16'h0002 : 16'h0001) && done_o)
    else $error("subtract length wrong");
  long_gap_a: assert property (accept && is_legal && is_long |=> // RULE3
    !ready_o ##1 ready_o)
    else $error("long op gap wrong");
  exor_flags_a: assert property (accept && (is_xrl_a || is_xrl_da
    || is_xrl_di) |=> cy_o == $past(cy_o) && ac_o == $past(ac_o)
    && ov_o == $past(ov_o)) // RULE11
    else $error("xor touched a flag");
  bit_address_a: assert property (accept && is_setbit |=> // RULE2
    bit_wr_o && bit_addr_o == $past(byte2_i) && cy_o == $past(cy_o))
    else $error("bit set address wrong");

  cover_subtract_with_borrow_ov_c: cover property (accept && is_subtract_with_borrow ##1 ov_o && cy_o);
  cover_short_relative_jump_back_c: cover property (accept && is_short_relative_jump && byte2_i[7]);
  cover_xrl_port_c: cover property (accept && is_xrl_di && dir_is_port_i);
  cover_digit_exchange_op_c: cover property (accept && is_digit_exchange_op ##2 accept && is_xch);

endmodule : cxs_exec
